// >>> sync_serial_pkg.sv
// constants and types shared by the synchronous serial port files
package sync_serial_pkg;
    // ------------------------------------------------------------
    // frame formats
    // ------------------------------------------------------------
    localparam logic [1:0] FMT_SPI = 2'h0;
    localparam logic [1:0] FMT_PULSE = 2'h1;
    localparam logic [1:0] FMT_CMD = 2'h2;

    // ------------------------------------------------------------
    // sizes and counts
    // ------------------------------------------------------------
    localparam int         WORD_W       = 16;
    localparam int         FIFO_DEPTH   = 8;
    localparam logic [3:0] MIN_SIZE_M1  = 4'h3;
    localparam logic [3:0] MAX_SIZE_M1  = 4'hF;
    localparam logic [4:0] CMD_BITS     = 5'h08;
    localparam logic [3:0] CMD_SIZE_M1  = 4'h7;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic       FRAME_RST    = 1'b1;
    localparam logic [4:0] BITCNT_RST   = 5'h00;
    localparam logic [15:0] DIVCNT_RST  = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_SYNC  = 3'h2,
        ST_SHIFT = 3'h4
    } engine_state_t;
endpackage

// >>> fifo_if.sv
// handshake carrier between a word fifo and its writer and reader
`timescale 1ns/100ps
interface fifo_if #(parameter int W = 16);
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;

    modport store  (input wr_valid, input wr_data, output wr_ready,
                    output rd_valid, output rd_data, input rd_ready);
    modport writer (output wr_valid, output wr_data, input wr_ready);
    modport reader (input rd_valid, input rd_data, output rd_ready);
endinterface

// >>> word_fifo.sv
// synchronous word fifo with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic reset,
    fifo_if.store    port
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gen_bad_depth
        $error("word_fifo depth must be a power of two of at least two");
    end

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0]  wp_r;
    logic [AW:0]  rp_r;
    logic         full;
    logic         empty;

    assign empty         = (wp_r == rp_r);
    assign full          = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign port.wr_ready = !full;
    assign port.rd_valid = !empty;
    assign port.rd_data  = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (port.wr_valid && !full) begin
            mem_r[wp_r[AW-1:0]] <= port.wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (port.wr_valid && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (port.rd_ready && !empty) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule

// >>> sync_serial_port.sv
// synchronous serial port: fifos, bit-rate generator and frame engine
`timescale 1ns/100ps
// Contract
// [R01] three frame formats selectable: four-wire, command/response, frame-pulse
// [R02] frame length programmable from 4 to 16 bits, both directions; the command of the command/response format is always 8 bits
// [R03] received bits become words; written words are shifted out serially
// [R04] separate transmit and receive fifos, eight 16-bit words each
// [R05] port runs as master driving clock and frame, or as slave
// [R06] a slave can be told never to drive its data output
// [R07] master clock comes from prescaler then bit-rate divider
// [R08] loopback mode feeds transmitted data back into own receiver
// [R09] fifo empty, not-full, not-empty and busy status are visible
module sync_serial_port #(
    parameter int WORD_W     = sync_serial_pkg::WORD_W,
    parameter int FIFO_DEPTH = sync_serial_pkg::FIFO_DEPTH
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    // configuration
    input  wire logic        port_enable,
    input  wire logic        master_en,
    input  wire logic [1:0]  frame_format,
    input  wire logic [3:0]  data_size_m1,
    input  wire logic        slave_out_disable,
    input  wire logic [7:0]  prescale,
    input  wire logic [7:0]  bit_rate_div,
    input  wire logic        loopback,
    // software word streams
    input  wire logic        tx_valid,
    input  wire logic [15:0] tx_data,
    output logic             tx_ready,
    output logic             rx_valid,
    output logic [15:0]      rx_data,
    input  wire logic        rx_ready,
    // status
    output logic             tx_empty,
    output logic             tx_not_full,
    output logic             rx_not_empty,
    output logic             busy,
    // pins
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    input  wire logic        frame_in,
    output logic             frame_out,
    output logic             frame_oe,
    input  wire logic        rxd,
    output logic             txd,
    output logic             txd_oe
);
    if (WORD_W != 16) begin : gen_bad_width
        $error("sync_serial_port supports a 16-bit word only");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // frame size below the smallest legal value is clamped up
    function automatic logic [3:0] clamp_size(input logic [3:0] s);
        return (s < sync_serial_pkg::MIN_SIZE_M1) ? sync_serial_pkg::MIN_SIZE_M1 : s;
    endfunction

    // move the frame's msb to bit 15 so the shifter always sends bit 15
    function automatic logic [15:0] msb_align(input logic [15:0] w, input logic [3:0] s);
        return w << (sync_serial_pkg::MAX_SIZE_M1 - s);
    endfunction

    // half period in mclk cycles; prescale lsb ignored so it acts as even
    function automatic logic [15:0] half_period(input logic [7:0] p, input logic [7:0] d);
        logic [6:0]  ph;
        logic [15:0] prod;
        ph   = (p[7:1] == 7'h00) ? 7'h01 : p[7:1];
        prod = {9'h000, ph} * ({8'h00, d} + 16'h0001);
        return prod;
    endfunction

    // ------------------------------------------------------------
    // fifos
    // ------------------------------------------------------------
    fifo_if #(.W(WORD_W)) tx_q ();
    fifo_if #(.W(WORD_W)) rx_q ();

    word_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) tx_fifo ( // [R04]
        .mclk  (mclk),
        .reset (reset),
        .port  (tx_q)
    );
    word_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) rx_fifo ( // [R04]
        .mclk  (mclk),
        .reset (reset),
        .port  (rx_q)
    );

    assign tx_q.wr_valid = tx_valid;
    assign tx_q.wr_data  = tx_data;
    assign tx_ready      = tx_q.wr_ready;
    assign rx_valid      = rx_q.rd_valid;
    assign rx_data       = rx_q.rd_data;
    assign rx_q.rd_ready = rx_ready;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic frame_s1_r, frame_s2_r, frame_s3_r;
    logic rxd_s1_r, rxd_s2_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            sclk_s1_r  <= 1'b0;
            sclk_s2_r  <= 1'b0;
            sclk_s3_r  <= 1'b0;
            frame_s1_r <= 1'b1;
            frame_s2_r <= 1'b1;
            frame_s3_r <= 1'b1;
            rxd_s1_r   <= 1'b0;
            rxd_s2_r   <= 1'b0;
        end else begin
            sclk_s1_r  <= sclk_in;
            sclk_s2_r  <= sclk_s1_r;
            sclk_s3_r  <= sclk_s2_r;
            frame_s1_r <= frame_in;
            frame_s2_r <= frame_s1_r;
            frame_s3_r <= frame_s2_r;
            rxd_s1_r   <= rxd;
            rxd_s2_r   <= rxd_s1_r;
        end
    end

    // ------------------------------------------------------------
    // bit-rate generator
    // ------------------------------------------------------------
    sync_serial_pkg::engine_state_t state_r;
    logic [15:0] div_cnt_r;
    logic        sclk_r;
    logic [15:0] half_m1;
    logic        running;
    logic        tick;

    assign half_m1 = half_period(prescale, bit_rate_div) - 16'h0001;
    // idle clock only runs to bring a high clock back to low
    assign running = (state_r != sync_serial_pkg::ST_IDLE) || sclk_r;
    assign tick    = running && (div_cnt_r >= half_m1);

    always_ff @(posedge mclk) begin
        if (reset || !master_en || !port_enable) begin
            div_cnt_r <= sync_serial_pkg::DIVCNT_RST;
            sclk_r    <= 1'b0;
        end else if (tick) begin // [R07]
            div_cnt_r <= sync_serial_pkg::DIVCNT_RST;
            sclk_r    <= !sclk_r;
        end else if (running) begin
            div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // edge selection and frame start
    // ------------------------------------------------------------
    logic fmt_pulse, fmt_cmd;
    logic rise, fall, lead_ev, trail_ev;
    logic m_start, s_start;
    logic phase_r, pend_r, frame_r;
    logic [4:0]  bit_cnt_r;
    logic [4:0]  nbits;
    logic [3:0]  size;
    logic [15:0] sh_tx_r, sh_rx_r;
    logic        rx_bit, recv, last, frame_rise, slave_sw;
    logic [15:0] tx_load;

    assign fmt_pulse = (frame_format == sync_serial_pkg::FMT_PULSE); // [R01]
    assign fmt_cmd = (frame_format == sync_serial_pkg::FMT_CMD); // [R01]
    assign size    = clamp_size(data_size_m1); // [R02]
    assign nbits   = (fmt_cmd && !phase_r) ? sync_serial_pkg::CMD_BITS
                                           : {1'b0, size} + 5'h01; // [R02]

    assign rise = master_en ? (tick && !sclk_r) : (sclk_s2_r && !sclk_s3_r); // [R05]
    assign fall = master_en ? (tick && sclk_r) : (!sclk_s2_r && sclk_s3_r); // [R05]
    // frame-pulse format launches on rise and samples on fall
    assign lead_ev  = fmt_pulse ? rise : fall;
    assign trail_ev = fmt_pulse ? fall : rise;

    assign m_start = master_en && port_enable && (state_r == sync_serial_pkg::ST_IDLE)
                     && !sclk_r && tx_q.rd_valid; // [R05]
    assign s_start = !master_en && port_enable && (state_r == sync_serial_pkg::ST_IDLE)
                     && (fmt_pulse ? (trail_ev && frame_s2_r) : (!frame_s2_r && frame_s3_r));

    // command phase goes master to slave, answer phase slave to master
    assign recv       = !fmt_cmd || (phase_r == master_en);
    assign last       = pend_r && (bit_cnt_r == nbits);
    assign frame_rise = !master_en && !fmt_pulse && frame_s2_r && !frame_s3_r;
    assign slave_sw   = !master_en && fmt_cmd && !phase_r && lead_ev && last
                        && (state_r == sync_serial_pkg::ST_SHIFT);
    assign rx_bit     = loopback ? sh_tx_r[15] : rxd_s2_r; // [R08]
    assign tx_load    = tx_q.rd_valid
                        ? msb_align(tx_q.rd_data, fmt_cmd ? sync_serial_pkg::CMD_SIZE_M1 : size)
                        : 16'h0000;

    // a slave with nothing queued sends zeros rather than stalling the master
    assign tx_q.rd_ready = m_start || (s_start && !fmt_cmd) || slave_sw; // [R03]
    assign rx_q.wr_valid = (state_r == sync_serial_pkg::ST_SHIFT) && recv && last
                           && (lead_ev || frame_rise); // [R03]
    assign rx_q.wr_data  = sh_rx_r;

    // ------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r   <= sync_serial_pkg::ST_IDLE;
            frame_r   <= sync_serial_pkg::FRAME_RST;
            bit_cnt_r <= sync_serial_pkg::BITCNT_RST;
            pend_r    <= 1'b0;
            phase_r   <= 1'b0;
            sh_tx_r   <= 16'h0000;
            sh_rx_r   <= 16'h0000;
        end else if (!port_enable) begin
            state_r <= sync_serial_pkg::ST_IDLE;
            frame_r <= !fmt_pulse;
            pend_r  <= 1'b0;
        end else begin
            case (state_r)
                sync_serial_pkg::ST_IDLE: begin
                    frame_r <= !fmt_pulse;
                    if (m_start || s_start) begin
                        sh_tx_r   <= (s_start && fmt_cmd) ? 16'h0000 : tx_load;
                        sh_rx_r   <= 16'h0000;
                        bit_cnt_r <= sync_serial_pkg::BITCNT_RST;
                        pend_r    <= 1'b0;
                        phase_r   <= 1'b0;
                        // master frame pulse owns one clock before the msb
                        state_r <= (m_start && fmt_pulse) ? sync_serial_pkg::ST_SYNC
                                                          : sync_serial_pkg::ST_SHIFT;
                        frame_r <= m_start && fmt_pulse; // [R01]
                    end
                end
                sync_serial_pkg::ST_SYNC: begin
                    if (trail_ev) begin
                        state_r <= sync_serial_pkg::ST_SHIFT;
                        frame_r <= 1'b0;
                    end
                end
                sync_serial_pkg::ST_SHIFT: begin
                    if (frame_rise) begin
                        // external master ended the frame
                        state_r <= sync_serial_pkg::ST_IDLE;
                    end else if (trail_ev) begin
                        sh_rx_r   <= {sh_rx_r[14:0], rx_bit}; // [R03]
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        pend_r    <= 1'b1;
                    end else if (lead_ev && last) begin
                        if (fmt_cmd && !phase_r) begin
                            phase_r   <= 1'b1;
                            bit_cnt_r <= sync_serial_pkg::BITCNT_RST;
                            pend_r    <= 1'b0;
                            sh_tx_r   <= master_en ? 16'h0000 : tx_load;
                            // command bits must not linger above a short answer
                            sh_rx_r   <= 16'h0000; // [R03]
                        end else begin
                            state_r <= sync_serial_pkg::ST_IDLE;
                            frame_r <= !fmt_pulse;
                            pend_r  <= 1'b0;
                        end
                    end else if (lead_ev && pend_r) begin
                        sh_tx_r <= {sh_tx_r[14:0], 1'b0}; // [R03]
                        pend_r  <= 1'b0;
                    end
                end
                default: begin
                    state_r <= sync_serial_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pins and status
    // ------------------------------------------------------------
    assign sclk_out  = sclk_r;
    assign sclk_oe   = master_en && port_enable; // [R05]
    assign frame_out = frame_r;
    assign frame_oe  = master_en && port_enable; // [R05]
    assign txd       = sh_tx_r[15];
    // loopback keeps the data pin quiet so the test does not disturb the link
    assign txd_oe    = port_enable && !loopback
                       && (master_en || (!slave_out_disable
                           && (state_r != sync_serial_pkg::ST_IDLE))); // [R06] [R08]

    assign tx_empty     = !tx_q.rd_valid; // [R09]
    assign tx_not_full  = tx_q.wr_ready; // [R09]
    assign rx_not_empty = rx_q.rd_valid; // [R09]
    assign busy         = (state_r != sync_serial_pkg::ST_IDLE) || tx_q.rd_valid; // [R09]
endmodule

// >>> sync_serial_port_asserts.sv
// concurrent checks on the synchronous serial port pins and status
`timescale 1ns/100ps
module sync_serial_port_asserts (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       port_enable,
    input wire logic       master_en,
    input wire logic [1:0] frame_format,
    input wire logic [3:0] data_size_m1,
    input wire logic       slave_out_disable,
    input wire logic [7:0] prescale,
    input wire logic [7:0] bit_rate_div,
    input wire logic       loopback,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       tx_empty,
    input wire logic       tx_not_full,
    input wire logic       rx_valid,
    input wire logic       rx_not_empty,
    input wire logic       busy,
    input wire logic       sclk_out,
    input wire logic       sclk_oe,
    input wire logic       frame_out,
    input wire logic       txd_oe
);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    logic [15:0] half;
    logic [15:0] hi_cnt_r;
    logic [4:0]  rise_cnt_r;
    logic [4:0]  size;
    logic        spi_m;
    // a prescale of 0 or 1 behaves as 2
    assign half = {8'h00, (prescale[7:1] == 7'h00) ? 8'h01 : {1'b0, prescale[7:1]}}
                  * ({8'h00, bit_rate_div} + 16'h0001);
    assign size = (data_size_m1 < 4'h3) ? 5'h04 : {1'b0, data_size_m1} + 5'h01;
    assign spi_m = master_en && port_enable && frame_format == sync_serial_pkg::FMT_SPI;
    always_ff @(posedge mclk) begin
        if (reset || !sclk_out) hi_cnt_r <= 16'h0000;
        else hi_cnt_r <= hi_cnt_r + 16'h0001;
    end
    always_ff @(posedge mclk) begin
        if (reset || frame_out) rise_cnt_r <= 5'h00;
        else if ($rose(sclk_out)) rise_cnt_r <= rise_cnt_r + 5'h01;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    reset_values_a: assert property (disable iff (1'b0) reset |=>
        !sclk_out && frame_out && tx_empty && !rx_valid && !busy) else $error("bad reset value");
    ready_status_a: assert property (tx_ready == tx_not_full
        && (tx_not_full || !tx_empty)) else $error("fifo status flags disagree");
    write_taken_a: assert property (tx_valid && tx_ready |=> !tx_empty && busy)
        else $error("written word not held");
    pending_busy_a: assert property (!tx_empty |-> busy)
        else $error("idle with words pending");
    loop_quiet_a: assert property (loopback |-> !txd_oe)
        else $error("data driven in loopback");
    slave_quiet_a: assert property (!master_en && slave_out_disable |-> !txd_oe)
        else $error("silenced slave drives data");
    clock_drive_a: assert property (sclk_oe == (master_en && port_enable))
        else $error("clock enable wrong");
    half_period_a: assert property (spi_m && $fell(sclk_out) |-> hi_cnt_r == half)
        else $error("clock high time wrong");
    frame_bits_a: assert property (spi_m && $rose(frame_out) |->
        rise_cnt_r == size && rx_not_empty) else $error("frame bit count wrong");
    idle_low_a: assert property (spi_m && frame_out |-> !sclk_out)
        else $error("clock moves outside frame");
endmodule

bind sync_serial_port sync_serial_port_asserts i_sync_serial_port_asserts (
    .mclk(mclk), .reset(reset), .port_enable(port_enable), .master_en(master_en),
    .frame_format(frame_format), .data_size_m1(data_size_m1),
    .slave_out_disable(slave_out_disable), .prescale(prescale), .bit_rate_div(bit_rate_div),
    .loopback(loopback), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_empty(tx_empty),
    .tx_not_full(tx_not_full), .rx_valid(rx_valid), .rx_not_empty(rx_not_empty),
    .busy(busy), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .frame_out(frame_out),
    .txd_oe(txd_oe));

// >>> spi_peripheral_model.sv
// four-wire peripheral that answers a master on the serial pins
`timescale 1ns/100ps
module spi_peripheral_model (
    input  wire logic        sclk,
    input  wire logic        sel_n,
    input  wire logic        mosi,
    input  wire logic [3:0]  size_m1,
    input  wire logic [15:0] reply,
    output logic             miso,
    output logic [15:0]      got
);
    int idx;
    initial miso = 1'b0;
    initial got = 16'h0000;
    // reply msb is presented as soon as the frame opens
    always @(negedge sel_n) begin
        idx = int'(size_m1);
        miso = reply[idx];
        got = 16'h0000;
    end
    always @(posedge sclk) if (!sel_n) got = {got[14:0], mosi};
    always @(negedge sclk) if (!sel_n && idx > 0) begin
        idx = idx - 1;
        miso = reply[idx];
    end
    // a released line shows the inverse so a stale bit cannot pass
    always @(posedge sel_n) miso = ~miso;
endmodule

// >>> sync_serial_port_bench.sv
// self-checking bench for the synchronous serial port
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module sync_serial_port_bench;
    logic mclk, tx_ready, rx_valid, tx_empty, tx_not_full, rx_not_empty, busy;
    logic sclk_out, sclk_oe, frame_out, frame_oe, txd, txd_oe, pmiso;
    logic reset = 1'b1, port_enable = 1'b0, master_en = 1'b1, slave_out_disable = 1'b0;
    logic loopback = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
    logic sclk_in = 1'b0, frame_in = 1'b1;
    logic [1:0]  frame_format = 2'h0;
    logic [3:0]  data_size_m1 = 4'h7;
    logic [7:0]  prescale = 8'h02, bit_rate_div = 8'h05;
    logic [15:0] tx_data = 16'h0000, reply = 16'h0000, rx_data, got;
    int num_errors = 0, check_count = 0, cyc = 0;

    sync_serial_port i_sync_serial_port (.mclk(mclk), .reset(reset),
        .port_enable(port_enable), .master_en(master_en), .frame_format(frame_format),
        .data_size_m1(data_size_m1), .slave_out_disable(slave_out_disable),
        .prescale(prescale), .bit_rate_div(bit_rate_div), .loopback(loopback),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_empty(tx_empty), .tx_not_full(tx_not_full),
        .rx_not_empty(rx_not_empty), .busy(busy), .sclk_in(sclk_in), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .frame_in(frame_in), .frame_out(frame_out), .frame_oe(frame_oe),
        .rxd(pmiso), .txd(txd), .txd_oe(txd_oe));
    spi_peripheral_model i_spi_peripheral_model (.sclk(sclk_out), .sel_n(frame_out | !frame_oe),
        .mosi(txd), .size_m1(data_size_m1), .reply(reply), .miso(pmiso), .got(got));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("[FAIL] %0t run did not finish", $time);
            report_and_stop();
        end
    end

    function automatic logic [15:0] mask(input logic [3:0] s);
        mask = 16'hFFFF >> (4'hF - s);
    endfunction
    task automatic push(input logic [15:0] d);
        int n = 0;
        tx_valid <= 1'b1;
        tx_data <= d;
        @(posedge mclk);
        while (tx_ready !== 1'b1 && n < 2000) begin
            n++;
            @(posedge mclk);
        end
        `CHK(n < 2000, 1'b1);
        tx_valid <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic pop(input logic [15:0] e);
        int n = 0;
        rx_ready <= 1'b1;
        @(posedge mclk);
        while (rx_valid !== 1'b1 && n < 2000) begin
            n++;
            @(posedge mclk);
        end
        `CHK(n < 2000, 1'b1);
        `CHK(rx_data, e);
        rx_ready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wait_idle;
        int n = 0;
        @(posedge mclk);
        while ((busy !== 1'b0 || sclk_out !== 1'b0
                || frame_out !== (frame_format != sync_serial_pkg::FMT_PULSE)) && n < 2000) begin
            n++;
            @(posedge mclk);
        end
        `CHK(n < 2000, 1'b1);
    endtask
    task automatic t_reset;
        `CHK({tx_empty, tx_ready, rx_valid, busy, frame_out, sclk_out}, 6'h32);
    endtask
    task automatic t_master(input logic [3:0] s, input logic [15:0] w, input logic [15:0] r);
        data_size_m1 <= s;
        reply <= r;
        prescale <= (s == 4'h7) ? 8'h06 : 8'h02;
        bit_rate_div <= (s == 4'h7) ? 8'h01 : 8'h05;
        push(w);
        pop(r & mask(s));
        wait_idle();
        `CHK(got, w & mask(s));
    endtask
    task automatic t_formats;
        logic [1:0] f[3] = '{sync_serial_pkg::FMT_SPI, sync_serial_pkg::FMT_PULSE,
                             sync_serial_pkg::FMT_CMD};
        loopback <= 1'b1;
        data_size_m1 <= 4'hF;
        for (int i = 0; i < 3; i++) begin
            frame_format <= f[i];
            push(16'hC3A5);
            pop((f[i] == sync_serial_pkg::FMT_CMD) ? 16'h0000 : 16'hC3A5);
            `CHK(txd_oe, 1'b0);
            wait_idle();
        end
    endtask
    task automatic t_fill;
        port_enable <= 1'b0;
        frame_format <= sync_serial_pkg::FMT_SPI;
        for (int i = 0; i < 8; i++) push(16'(16'h1111 * (i + 1)));
        @(posedge mclk);
        `CHK({tx_ready, tx_not_full, busy}, 3'h1);
        port_enable <= 1'b1;
        for (int i = 0; i < 8; i++) pop(16'(16'h1111 * (i + 1)));
        wait_idle();
        `CHK({tx_empty, rx_not_empty}, 2'h2);
    endtask
    // bench acts as the external master; half period well above the pin latency
    task automatic t_slave(input logic dis);
        logic [3:0] seen = 4'h0;
        loopback <= 1'b0;
        master_en <= 1'b0;
        slave_out_disable <= dis;
        data_size_m1 <= 4'h3;
        push(16'h0009);
        frame_in <= 1'b0;
        repeat (8) @(posedge mclk);
        `CHK(txd_oe, !dis);
        for (int i = 0; i < 4; i++) begin
            seen = {seen[2:0], txd};
            sclk_in <= 1'b1;
            repeat (8) @(posedge mclk);
            sclk_in <= 1'b0;
            repeat (8) @(posedge mclk);
        end
        frame_in <= 1'b1;
        repeat (8) @(posedge mclk);
        `CHK({seen, sclk_oe, busy}, 6'h24);
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_reset();
        port_enable <= 1'b1;
        t_master(4'h3, 16'hFFF9, 16'h000A);
        t_master(4'h4, 16'h0015, 16'h0019);
        t_master(4'h7, 16'h00A5, 16'h005C);
        t_master(4'hF, 16'hB00D, 16'h8E71);
        t_formats();
        t_fill();
        t_slave(1'b0);
        t_slave(1'b1);
        report_and_stop();
    end
endmodule
